// >>> rgbh_regs.svh
// Timing constants, field widths and reset values for the RGB panel host.
// Assumes a 40 MHz system clock; included by rgbh_spi and rgbh_host.
// Behaviour
// - Panel reset output stays low until host releases it, before any traffic.
// - A frame sync pulse marks the start of every frame.
// - A line sync pulse marks the start of every line.
// - Data enable is high only on cycles carrying active-area pixels.
// - Pixels are driven on an eighteen-line bus, sampled by pixel clock.
// - Line sync at least 2, back porch at least 4, sum at most 31.
// - Line front porch is at least 2 pixel clocks.
// - Frame sync at least 1 line, back porch at least 1, sum at most 127.
// - Frame front porch is at least 1 line.
// - Typical timing is 10/10/38 clocks and 4/4/8 lines.
// - Host drives chip select and serial clock, shares the serial data line.
// - Chip select stays high at least 40 ns between serial accesses.
// - Read serial clock period at least 150 ns, phases 60 ns; write 66 ns.
// - Serial-only or RGB at 6, 16 or 18 bits; serial config in all modes.
`ifndef RGBH_REGS_SVH
`define RGBH_REGS_SVH

`define RGBH_CLK_MHZ        40
`define RGBH_H_ACTIVE       240
`define RGBH_V_ACTIVE       320
`define RGBH_HPW_MIN        2
`define RGBH_HBP_MIN        4
`define RGBH_HSUM_MAX       31
`define RGBH_HFP_MIN        2
`define RGBH_VS_MIN         1
`define RGBH_VBP_MIN        1
`define RGBH_VSUM_MAX       127
`define RGBH_VFP_MIN        1
`define RGBH_HPW_TYP        8'h0a
`define RGBH_HBP_TYP        8'h0a
`define RGBH_HFP_TYP        8'h26
`define RGBH_VS_TYP         8'h04
`define RGBH_VBP_TYP        8'h04
`define RGBH_VFP_TYP        8'h08
`define RGBH_T_CSH_NS       40
`define RGBH_T_RD_HALF_NS   75
`define RGBH_T_WR_HALF_NS   33
`define RGBH_CSH_CYC  ((`RGBH_T_CSH_NS*`RGBH_CLK_MHZ+999)/1000)
`define RGBH_RD_HALF_CYC ((`RGBH_T_RD_HALF_NS*`RGBH_CLK_MHZ+999)/1000)
`define RGBH_WR_HALF_CYC ((`RGBH_T_WR_HALF_NS*`RGBH_CLK_MHZ+999)/1000)
`define RGBH_SPI_BITS       9
`define RGBH_BUS_W          18
`define RGBH_DIV_W          4
`define RGBH_RST_CYC        16

`endif

// >>> rgbh_pkg.sv
// Types shared by the RGB panel host modules.
// Assumes rgbh_regs.svh for the numeric constants.
package rgbh_pkg;
  typedef enum logic [1:0] {
    RGBH_MODE_SERIAL = 2'b00,
    RGBH_MODE_B6     = 2'b01,
    RGBH_MODE_B16    = 2'b10,
    RGBH_MODE_B18    = 2'b11
  } rgbh_mode_t;

  typedef enum logic [1:0] {
    RGBH_SP_IDLE = 2'b00,
    RGBH_SP_LOW  = 2'b01,
    RGBH_SP_HIGH = 2'b10,
    RGBH_SP_GAP  = 2'b11
  } rgbh_spi_st_t;

  typedef enum logic [1:0] {
    RGBH_PH_SYNC  = 2'b00,
    RGBH_PH_BACK  = 2'b01,
    RGBH_PH_ACT   = 2'b10,
    RGBH_PH_FRONT = 2'b11
  } rgbh_phase_t;
endpackage

// >>> rgbh_spi.sv
// 3-wire serial configuration master of the RGB panel host.
// Runs on the 40 MHz system clock; data line is split into in/out/enable.
`timescale 1ns/1ps
`include "rgbh_regs.svh"
module rgbh_spi
  import rgbh_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_start,
  input  wire logic        i_read,
  input  wire logic [8:0]  i_word,
  input  wire logic        i_sda,
  output logic             o_busy,
  output logic             o_done,
  output logic [7:0]       o_rdata,
  output logic             o_cs_n,
  output logic             o_scl,
  output logic             o_sda,
  output logic             o_sda_oe
);
  rgbh_spi_st_t state;
  logic [3:0]   bit_cnt;
  logic [2:0]   tmr;
  logic [8:0]   shreg;
  logic         rd;
  logic         sda_m;
  logic         sda_s;
  wire  [2:0]   half = rd ? 3'(`RGBH_RD_HALF_CYC)
                          : 3'(`RGBH_WR_HALF_CYC);
  wire          tmr_end = (tmr == half - 3'h1);
  wire          last = (bit_cnt == 4'(`RGBH_SPI_BITS - 1));
  // Readback only after the first bit; the first bit stays driven
  wire          rd_phase = rd && (bit_cnt != 4'h0);

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sda_m <= 1'b0;
      sda_s <= 1'b0;
    end
    else
    begin
      sda_m <= i_sda;
      sda_s <= sda_m;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state    <= RGBH_SP_IDLE;
      bit_cnt  <= 4'h0;
      tmr      <= 3'h0;
      shreg    <= 9'h000;
      rd       <= 1'b0;
      o_busy   <= 1'b0;
      o_done   <= 1'b0;
      o_rdata  <= 8'h00;
      o_cs_n   <= 1'b1;
      o_scl    <= 1'b0;
      o_sda    <= 1'b0;
      o_sda_oe <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      case (state)
        RGBH_SP_IDLE:
        begin
          if (i_start)
          begin
            state    <= RGBH_SP_LOW;
            shreg    <= i_word;
            rd       <= i_read;
            bit_cnt  <= 4'h0;
            tmr      <= 3'h0;
            o_busy   <= 1'b1;
            o_cs_n   <= 1'b0;
            o_sda    <= i_word[8];
            o_sda_oe <= 1'b1;
          end
        end
        RGBH_SP_LOW:
        begin
          tmr <= tmr + 3'h1;
          if (tmr_end)
          begin
            tmr   <= 3'h0;
            o_scl <= 1'b1;
            state <= RGBH_SP_HIGH;
            if (rd_phase)
              o_rdata <= {o_rdata[6:0], sda_s};
          end
        end
        RGBH_SP_HIGH:
        begin
          tmr <= tmr + 3'h1;
          if (tmr_end)
          begin
            tmr   <= 3'h0;
            o_scl <= 1'b0;
            if (last)
            begin
              state    <= RGBH_SP_GAP;
              o_cs_n   <= 1'b1;
              o_sda_oe <= 1'b0;
            end
            else
            begin
              state    <= RGBH_SP_LOW;
              bit_cnt  <= bit_cnt + 4'h1;
              shreg    <= {shreg[7:0], 1'b0};
              o_sda    <= shreg[7];
              o_sda_oe <= !rd;
            end
          end
        end
        RGBH_SP_GAP:
        begin
          tmr <= tmr + 3'h1;
          if (tmr == 3'(`RGBH_CSH_CYC - 1))
          begin
            state  <= RGBH_SP_IDLE;
            o_busy <= 1'b0;
            o_done <= 1'b1;
          end
        end
        default: state <= RGBH_SP_IDLE;
      endcase
    end
  end
endmodule // rgbh_spi

// >>> rgbh_host.sv
// Top of the RGB panel host: timing generator, pixel bus and serial master.
// Pixel clock is derived here by a divider; pixels come from user ports.
`timescale 1ns/1ps
`include "rgbh_regs.svh"
module rgbh_host
  import rgbh_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_panel_run,
  input  wire rgbh_mode_t  i_mode,
  input  wire logic [7:0]  i_hpw,
  input  wire logic [7:0]  i_hbp,
  input  wire logic [7:0]  i_hfp,
  input  wire logic [7:0]  i_frame_sync_width,
  input  wire logic [7:0]  i_vbp,
  input  wire logic [7:0]  i_vfp,
  input  wire logic        i_timing_load,
  input  wire logic [17:0] i_pixel,
  input  wire logic        i_cfg_start,
  input  wire logic        i_cfg_read,
  input  wire logic [8:0]  i_cfg_word,
  input  wire logic        i_sda,
  output logic             o_pixel_req,
  output logic             o_timing_err,
  output logic             o_cfg_busy,
  output logic             o_cfg_done,
  output logic [7:0]       o_cfg_rdata,
  output logic             o_panel_rst_n,
  output logic             o_cs_n,
  output logic             o_scl,
  output logic             o_sda,
  output logic             o_sda_oe,
  output logic             o_pixel_clock,
  output logic             o_frame_sync,
  output logic             o_line_sync,
  output logic             o_data_en,
  output logic [17:0]      o_pixel_data_bus
);
  logic [3:0]  rst_cnt;
  logic [3:0]  div;
  logic [7:0]  hpw;
  logic [7:0]  hbp;
  logic [7:0]  hfp;
  logic [7:0]  vsw;
  logic [7:0]  vbp;
  logic [7:0]  vfp;
  rgbh_phase_t hph;
  rgbh_phase_t vph;
  logic [8:0]  hcnt;
  logic [8:0]  vcnt;
  logic        rgb_on;

  function automatic logic h_ok(input logic [7:0] w, input logic [7:0] b,
                                input logic [7:0] f);
    h_ok = (w >= 8'(`RGBH_HPW_MIN)) && (b >= 8'(`RGBH_HBP_MIN))
        && ({1'b0, w} + {1'b0, b} <= 9'(`RGBH_HSUM_MAX))
        && (f >= 8'(`RGBH_HFP_MIN));
  endfunction

  function automatic logic v_ok(input logic [7:0] w, input logic [7:0] b,
                                input logic [7:0] f);
    v_ok = (w >= 8'(`RGBH_VS_MIN)) && (b >= 8'(`RGBH_VBP_MIN))
        && ({1'b0, w} + {1'b0, b} <= 9'(`RGBH_VSUM_MAX))
        && (f >= 8'(`RGBH_VFP_MIN));
  endfunction

  // Phase length in counts, shared by both axes
  function automatic logic [8:0] ph_len(input rgbh_phase_t p,
      input logic [7:0] w, input logic [7:0] b, input logic [7:0] f,
      input logic [8:0] act);
    case (p)
      RGBH_PH_SYNC:  ph_len = {1'b0, w};
      RGBH_PH_BACK:  ph_len = {1'b0, b};
      RGBH_PH_ACT:   ph_len = act;
      default:       ph_len = {1'b0, f};
    endcase
  endfunction

  wire set_ok = h_ok(i_hpw, i_hbp, i_hfp)
             && v_ok(i_frame_sync_width, i_vbp, i_vfp);
  // Pixel clock rises at div half and falls when div wraps; outputs change with that fall
  wire div_half = (div == 4'((1 << (`RGBH_DIV_W - 1)) - 1));
  wire div_wrap = (div == 4'hf);
  wire h_last = (hcnt == ph_len(hph, hpw, hbp, hfp,
                                9'(`RGBH_H_ACTIVE)) - 9'h001);
  wire v_last = (vcnt == ph_len(vph, vsw, vbp, vfp,
                                9'(`RGBH_V_ACTIVE)) - 9'h001);
  wire line_end = (hph == RGBH_PH_FRONT) && h_last;
  wire active = (hph == RGBH_PH_ACT) && (vph == RGBH_PH_ACT);
  wire rst_done = (rst_cnt == 4'(`RGBH_RST_CYC - 1));
  wire [17:0] bus_sel = (i_mode == RGBH_MODE_B6)  ? {12'h000, i_pixel[5:0]}
                      : (i_mode == RGBH_MODE_B16) ? {2'h0, i_pixel[15:0]}
                      : i_pixel;

  // Panel reset held low until asked to run and a minimum time passed
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_cnt       <= 4'h0;
      o_panel_rst_n <= 1'b0;
    end
    else if (i_panel_run && !rst_done)
      rst_cnt <= rst_cnt + 4'h1;
    else if (i_panel_run)
      o_panel_rst_n <= 1'b1;
    else
    begin
      rst_cnt       <= 4'h0;
      o_panel_rst_n <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      hpw <= `RGBH_HPW_TYP;
      hbp <= `RGBH_HBP_TYP;
      hfp <= `RGBH_HFP_TYP;
      vsw <= `RGBH_VS_TYP;
      vbp <= `RGBH_VBP_TYP;
      vfp <= `RGBH_VFP_TYP;
      o_timing_err <= 1'b0;
    end
    else if (i_timing_load && set_ok)
    begin
      hpw <= i_hpw;
      hbp <= i_hbp;
      hfp <= i_hfp;
      vsw <= i_frame_sync_width;
      vbp <= i_vbp;
      vfp <= i_vfp;
      o_timing_err <= 1'b0;
    end
    else if (i_timing_load)
      o_timing_err <= 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      div           <= 4'h0;
      o_pixel_clock <= 1'b0;
      rgb_on        <= 1'b0;
    end
    else
    begin
      div           <= div + 4'h1;
      o_pixel_clock <= div_half ? 1'b1 : (div_wrap ? 1'b0 : o_pixel_clock);
      if (div_wrap)
        rgb_on <= o_panel_rst_n && (i_mode != RGBH_MODE_SERIAL);
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      hph  <= RGBH_PH_SYNC;
      vph  <= RGBH_PH_SYNC;
      hcnt <= 9'h000;
      vcnt <= 9'h000;
    end
    else if (!rgb_on)
    begin
      hph  <= RGBH_PH_SYNC;
      vph  <= RGBH_PH_SYNC;
      hcnt <= 9'h000;
      vcnt <= 9'h000;
    end
    else if (div_wrap)
    begin
      hcnt <= h_last ? 9'h000 : hcnt + 9'h001;
      if (h_last)
        hph <= rgbh_phase_t'(hph + 2'h1);
      if (line_end)
      begin
        vcnt <= v_last ? 9'h000 : vcnt + 9'h001;
        if (v_last)
          vph <= rgbh_phase_t'(vph + 2'h1);
      end
    end
  end

  // Panel pins update on the pixel clock's falling edge for setup; o_pixel_req pulses there for one cycle
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_frame_sync     <= 1'b0;
      o_line_sync      <= 1'b0;
      o_data_en        <= 1'b0;
      o_pixel_data_bus <= 18'h00000;
      o_pixel_req      <= 1'b0;
    end
    else
    begin
      o_pixel_req <= div_wrap && rgb_on && active;
      if (div_wrap)
      begin
        o_frame_sync     <= rgb_on && (vph == RGBH_PH_SYNC);
        o_line_sync      <= rgb_on && (hph == RGBH_PH_SYNC);
        o_data_en        <= rgb_on && active;
        o_pixel_data_bus <= (rgb_on && active) ? bus_sel : 18'h00000;
      end
    end
  end

  rgbh_spi u_spi
  (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_start  (i_cfg_start && o_panel_rst_n),
    .i_read   (i_cfg_read),
    .i_word   (i_cfg_word),
    .i_sda    (i_sda),
    .o_busy   (o_cfg_busy),
    .o_done   (o_cfg_done),
    .o_rdata  (o_cfg_rdata),
    .o_cs_n   (o_cs_n),
    .o_scl    (o_scl),
    .o_sda    (o_sda),
    .o_sda_oe (o_sda_oe)
  );
endmodule // rgbh_host

// >>> rgbh_sva.sv
// Port assertions for rgbh_host: serial framing and RGB line timing.
// Bound to rgbh_host from the bench top file; sees top ports only.
`timescale 1ns/1ps
module rgbh_sva
  import rgbh_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  input wire rgbh_mode_t  i_mode,
  input wire logic        i_cfg_start,
  input wire logic        i_cfg_read,
  input wire logic        o_cfg_busy,
  input wire logic        o_pixel_req,
  input wire logic        o_panel_rst_n,
  input wire logic        o_cs_n,
  input wire logic        o_scl,
  input wire logic        o_sda_oe,
  input wire logic        o_pixel_clock,
  input wire logic        o_line_sync,
  input wire logic        o_data_en,
  input wire logic [17:0] o_pixel_data_bus
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  logic       rd;
  logic [9:0] hi;
  logic [9:0] gap;
  logic [9:0] sb;
  // The gap and sb counters saturate so long blanking cannot wrap into a false pass
  wire [9:0] gap_inc = (gap == 10'h3ff) ? gap : gap + 10'h1;
  wire [9:0] sb_inc  = (sb == 10'h3ff) ? sb : sb + 10'h1;
  wire       ls_new  = o_line_sync && (hi == 10'h0);

  always_ff @(posedge i_clk or negedge i_arst_n)
    if (!i_arst_n)
    begin
      rd  <= 1'b0;
      hi  <= 10'h0;
      gap <= 10'h3ff;
      sb  <= 10'h0;
    end
    else
    begin
      rd  <= (i_cfg_start && !o_cfg_busy && o_panel_rst_n) ? i_cfg_read : rd;
      hi  <= o_line_sync ? hi + 10'h1 : 10'h0;
      gap <= o_data_en ? 10'h0 : gap_inc;
      // Start at one so sb equals the cycles since line sync rose
      sb  <= ls_new ? 10'h1 : sb_inc;
    end

  a_rst_quiet:
    assert property (!o_panel_rst_n |-> o_cs_n && !o_data_en)
    else $error("traffic while panel in reset");
  a_de_mode:
    assert property (o_data_en |-> i_mode != RGBH_MODE_SERIAL)
    else $error("data enable in serial-only mode");
  a_bus_idle:
    assert property (!o_data_en |-> o_pixel_data_bus == 18'h0)
    else $error("pixel bus busy outside active area");
  a_pin_wrap:
    assert property ($changed(o_data_en) || $changed(o_line_sync)
      |-> $fell(o_pixel_clock))
    else $error("rgb pins moved off the pixel clock fall");
  a_hsync_width:
    assert property ($fell(o_line_sync) |-> hi >= 10'h20)
    else $error("line sync shorter than two pixel clocks");
  a_sync_porch:
    assert property ($rose(o_data_en) |-> sb >= 10'h60 && sb <= 10'h1f0)
    else $error("line sync plus back porch out of range");
  a_front_porch:
    assert property ($rose(o_line_sync) |-> gap >= 10'h20)
    else $error("line front porch too short");
  a_cs_gap:
    assert property ($rose(o_cs_n) |-> o_cs_n [*2])
    else $error("chip select high gap too short");
  a_scl_write:
    assert property ($rose(o_scl) |-> o_scl [*2])
    else $error("serial clock high phase too short");
  a_scl_read:
    assert property (rd && $rose(o_scl) |-> o_scl [*3])
    else $error("read clock high phase too short");
  a_scl_rd_low:
    assert property (rd && $fell(o_scl) |-> !o_scl [*3])
    else $error("read clock low phase too short");
  a_req_on_de:
    assert property (o_pixel_req |-> o_data_en && $fell(o_pixel_clock))
    else $error("pixel request outside an enabled pixel");
  a_oe_in_cs:
    assert property (o_sda_oe |-> !o_cs_n)
    else $error("data line driven with chip select high");
endmodule // rgbh_sva

// >>> rgbh_panel.sv
// Behavioural panel: takes serial words, answers reads, measures lines.
// Driven by rgbh_host pins; o_sda is the resolved data line level.
`timescale 1ns/1ps
module rgbh_panel (
  input  wire logic        i_rst_n,
  input  wire logic        i_cs_n,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  input  wire logic        i_sda_oe,
  input  wire logic        i_pclk,
  input  wire logic        i_fs,
  input  wire logic        i_ls,
  input  wire logic        i_de,
  input  wire logic [17:0] i_bus,
  output logic             o_sda
);
  localparam logic [7:0] rd_byte = 8'hc5;
  logic [8:0]  rx = 9'h0;
  logic [8:0]  wr_word = 9'h0;
  logic [17:0] px = 18'h0;
  logic [17:0] l_px = 18'h0;
  logic        dv = 1'b0;
  logic        ls_q = 1'b0;
  int rise, hs, bp, dn, fp, vl, lines, v_start, l_hs, l_bp, l_de, l_fp;
  // No pull on the line: released with chip select high, it shows the inverse of the last bit
  assign o_sda = i_sda_oe ? i_sda : (!i_cs_n && rise > 0) ? dv : ~dv;
  always @(negedge i_cs_n)
    rise = 0;
  always @(posedge i_cs_n)
    wr_word = rx;
  always @(posedge i_scl)
    if (!i_cs_n)
    begin
      rx = {rx[7:0], o_sda};
      rise++;
    end
  always @(negedge i_scl)
    if (!i_cs_n && rise < 9)
      dv = rd_byte[8 - rise];
  always @(posedge i_pclk)
    if (i_rst_n)
    begin
      if (i_ls && !ls_q)
      begin
        l_hs = hs;
        l_bp = bp;
        l_de = dn;
        l_px = px;
        l_fp = fp;
        hs = 0;
        bp = 0;
        dn = 0;
        fp = 0;
        vl = i_fs ? 0 : vl + 1;
        lines++;
      end
      ls_q = i_ls;
      if (i_ls)
        hs++;
      else if (i_de)
      begin
        if (dn == 0)
          px = i_bus;
        if (dn == 0 && l_de == 0)
          v_start = vl;
        dn++;
      end
      else if (dn == 0)
        bp++;
      else
        fp++;
    end
endmodule // rgbh_panel

// >>> rgbh_host_bench.sv
// Self-checking bench for rgbh_host against the panel model.
// Needs rgbh_pkg, rgbh_sva and rgbh_panel compiled before it.
`timescale 1ns/1ps
module rgbh_host_bench;
  import rgbh_pkg::*;
  logic i_clk = 0, i_arst_n = 0, i_panel_run = 0;
  logic i_timing_load = 0, i_cfg_start = 0, i_cfg_read = 0;
  rgbh_mode_t  i_mode = RGBH_MODE_SERIAL;
  logic [7:0]  i_hpw = 0, i_hbp = 0, i_hfp = 0;
  logic [7:0]  i_frame_sync_width = 0, i_vbp = 0, i_vfp = 0;
  logic [17:0] i_pixel = 18'h2a5c3;
  logic [8:0]  i_cfg_word = 0;
  wire i_sda, o_pixel_req, o_timing_err, o_cfg_busy, o_cfg_done;
  wire o_panel_rst_n, o_cs_n, o_scl, o_sda, o_sda_oe, o_pixel_clock;
  wire o_frame_sync, o_line_sync, o_data_en;
  wire [7:0]  o_cfg_rdata;
  wire [17:0] o_pixel_data_bus;
  int err_total = 0, checked = 0, cycles = 0, n;
  int req_cnt = 0, req_line = 0;

  rgbh_host dut (.i_clk, .i_arst_n, .i_panel_run, .i_mode, .i_hpw, .i_hbp,
    .i_hfp, .i_frame_sync_width, .i_vbp, .i_vfp, .i_timing_load, .i_pixel,
    .i_cfg_start, .i_cfg_read, .i_cfg_word, .i_sda, .o_pixel_req,
    .o_timing_err, .o_cfg_busy, .o_cfg_done, .o_cfg_rdata, .o_panel_rst_n,
    .o_cs_n, .o_scl, .o_sda, .o_sda_oe, .o_pixel_clock, .o_frame_sync,
    .o_line_sync, .o_data_en, .o_pixel_data_bus);
  rgbh_panel panel (.i_rst_n(o_panel_rst_n), .i_cs_n(o_cs_n), .i_scl(o_scl),
    .i_sda(o_sda), .i_sda_oe(o_sda_oe), .i_pclk(o_pixel_clock),
    .i_fs(o_frame_sync), .i_ls(o_line_sync), .i_de(o_data_en),
    .i_bus(o_pixel_data_bus), .o_sda(i_sda));

  always #12.5 i_clk = ~i_clk;
  // Pixel requests of the line that has just ended
  always @(posedge o_line_sync)
  begin
    req_line = req_cnt;
    req_cnt = 0;
  end
  always @(posedge i_clk)
    if (o_pixel_req)
      req_cnt++;
  // Runs take about 28k cycles; the ceiling leaves ample margin
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic ld(logic [47:0] e);
    @(negedge i_clk);
    {i_hpw, i_hbp, i_hfp, i_frame_sync_width, i_vbp, i_vfp} = e;
    i_timing_load = 1;
    @(negedge i_clk);
    i_timing_load = 0;
    @(negedge i_clk);
  endtask
  task automatic cfg(logic [8:0] w, logic r);
    @(negedge i_clk);
    i_cfg_start = 1;
    i_cfg_read = r;
    i_cfg_word = w;
    @(negedge i_clk);
    i_cfg_start = 0;
    repeat (300)
    begin
      @(posedge i_clk);
      #1;
      if (o_cfg_done)
        break;
    end
    chk("done", o_cfg_done, 1);
  endtask
  task automatic t_load();
    logic [47:0] tab [8] = '{48'h010402010101, 48'h020302010101,
      48'h140c02010101, 48'h020401010101, 48'h020402000101,
      48'h020402010001, 48'h020402404001, 48'h020402010100};
    foreach (tab[k])
    begin
      ld(tab[k]);
      chk("err set", o_timing_err, 1);
    end
    ld(48'h1b0402010101);
    chk("err max", o_timing_err, 0);
    ld(48'h020402010101);
    chk("err min", o_timing_err, 0);
    $display("test load done");
  endtask
  task automatic t_run();
    chk("cs idle", o_cs_n, 1);
    i_cfg_start = 1;
    @(negedge i_clk);
    i_cfg_start = 0;
    @(negedge i_clk);
    chk("refused", o_cfg_busy, 0);
    i_panel_run = 1;
    n = 0;
    while (!o_panel_rst_n && n < 40)
    begin
      @(negedge i_clk);
      n++;
    end
    chk("release", n >= 16 && n <= 18, 1);
    $display("test reset done");
  endtask
  task automatic t_cfg();
    cfg(9'h12a, 0);
    chk("write word", panel.wr_word, 9'h12a);
    cfg(9'h1c9, 1);
    chk("read byte", o_cfg_rdata, 8'hc5);
    chk("read cmd", panel.wr_word[8], 1);
    $display("test serial done");
  endtask
  task automatic t_line(rgbh_mode_t m, logic [17:0] mask, int k);
    @(negedge i_clk);
    i_mode = m;
    n = panel.lines + k;
    repeat (20000)
    begin
      @(negedge i_clk);
      if (panel.lines >= n)
        break;
    end
    chk("lines", panel.lines >= n, 1);
    chk("sync", panel.l_hs, 2);
    chk("back", panel.l_bp, 4);
    chk("active", panel.l_de, 240);
    chk("requests", req_line, 240);
    chk("pixel", panel.l_px, i_pixel & mask);
    chk("front", panel.l_fp, 2);
    $display("test line done");
  endtask

  initial
  begin
    repeat (2) @(negedge i_clk);
    i_arst_n = 1;
    t_load();
    t_run();
    t_cfg();
    chk("serial idle", o_line_sync | o_data_en, 0);
    t_line(RGBH_MODE_B18, 18'h3ffff, 4);
    chk("v start", panel.v_start, 2);
    t_line(RGBH_MODE_B6, 18'h0003f, 2);
    t_line(RGBH_MODE_B16, 18'h0ffff, 2);
    report_and_stop();
  end
endmodule // rgbh_host_bench

bind rgbh_host rgbh_sva chk_i (.i_clk, .i_arst_n, .i_mode, .i_cfg_start,
  .i_cfg_read, .o_cfg_busy, .o_pixel_req, .o_panel_rst_n, .o_cs_n, .o_scl,
  .o_sda_oe,
  .o_pixel_clock, .o_line_sync, .o_data_en, .o_pixel_data_bus);
